// *** cesc_pkg.sv ***
// Constants and carrier types for the CAN error counter and status block
package cesc_pkg;

	// Register byte offsets
	localparam logic [7:0] CESC_OFF_ERR_COUNTERS = 8'h1c;
	localparam logic [7:0] CESC_OFF_ERR_FLAGS    = 8'h20;
	localparam int         CESC_ADDR_W           = 8;

	// Reset values
	localparam logic [31:0] CESC_RST_COUNTERS = 32'h0000_0000;
	localparam logic [7:0]  CESC_RST_COUNT    = 8'h00;

	// Field positions of error_counters
	localparam int CESC_POS_FRX_CNT = 24;
	localparam int CESC_POS_FTX_CNT = 16;
	localparam int CESC_POS_RX_CNT  = 8;
	localparam int CESC_POS_TX_CNT  = 0;

	// Field positions of error_flags
	localparam int CESC_POS_FAST_REC  = 31;
	localparam int CESC_POS_FAST_DOM  = 30;
	localparam int CESC_POS_FAST_CRC  = 28;
	localparam int CESC_POS_FAST_FORM = 27;
	localparam int CESC_POS_FAST_STUF = 26;
	localparam int CESC_POS_OVERRUN   = 21;
	localparam int CESC_POS_FAST_SUM  = 20;
	localparam int CESC_POS_RECOVERY  = 19;
	localparam int CESC_POS_SYNC      = 18;
	localparam int CESC_POS_TX_WIRQ   = 17;
	localparam int CESC_POS_RX_WIRQ   = 16;
	localparam int CESC_POS_STD_LSB   = 10;
	localparam int CESC_POS_TX_WARN   = 9;
	localparam int CESC_POS_RX_WARN   = 8;
	localparam int CESC_POS_STD_SUM   = 1;

	// Counter thresholds and steps
	localparam logic [7:0] CESC_WARN_LIMIT = 8'd96;
	localparam logic [8:0] CESC_CNT_MAX    = 9'h0ff;
	localparam logic [8:0] CESC_STEP_BIG   = 9'h008;
	localparam logic [8:0] CESC_STEP_ONE   = 9'h001;

	// AXI responses
	localparam logic [1:0] CESC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CESC_RESP_SLVERR = 2'h2;
	localparam logic [1:0] CESC_RESP_DECERR = 2'h3;
	localparam logic [3:0] CESC_STRB_FULL   = 4'hf;

	// Standard-phase causes, index i sits at flag bit 10+i
	typedef struct packed {
		logic bit_recessive_error;
		logic bit_dominant_error;
		logic acknowledge_error;
		logic checksum_error;
		logic form_error;
		logic stuffing_error;
	} cesc_std_err_t;

	// Fast data-phase causes
	typedef struct packed {
		logic fast_bit_recessive_error;
		logic fast_bit_dominant_error;
		logic fast_checksum_error;
		logic fast_form_error;
		logic fast_stuffing_error;
	} cesc_fast_err_t;

	// One-cycle error events from the protocol engine
	typedef struct packed {
		cesc_std_err_t  std_err;
		cesc_fast_err_t fast_err;
		logic           busoff_recovery;
	} cesc_evt_t;

	// One-cycle counter steps for one counter
	typedef struct packed {
		logic inc_one;
		logic inc_big;
		logic dec_one;
	} cesc_cnt_cmd_t;

	// Controller mode levels
	typedef struct packed {
		logic inactive;
		logic pretended_net;
		logic bus_off;
		logic bus_synchronized;
	} cesc_mode_t;

	// Counter values toward the protocol engine
	typedef struct packed {
		logic [7:0] fast_phase_rx_error_count;
		logic [7:0] fast_phase_tx_error_count;
		logic [7:0] rx_error_count;
		logic [7:0] tx_error_count;
	} cesc_counts_t;

endpackage

// *** cesc_err_cnt.sv ***
// Saturating 8-bit error counter with software load
`timescale 1ns/1ps
`default_nettype none
module cesc_err_cnt (
	// Clock and reset
	input  wire logic                   core_clk_in,
	input  wire logic                   rst_in,
	// Steps and load
	input  wire cesc_pkg::cesc_cnt_cmd_t cmd_in,
	input  wire logic                   load_in,
	input  wire logic [7:0]             load_val_in,
	// Value
	output logic [7:0]                  count_out
);
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic [8:0] sum;

	always_comb begin
		sum = {1'b0, count_q};
		if (cmd_in.inc_big) begin
			sum = sum + cesc_pkg::CESC_STEP_BIG;
		end else if (cmd_in.inc_one) begin
			sum = sum + cesc_pkg::CESC_STEP_ONE;
		end else if (cmd_in.dec_one && count_q != cesc_pkg::CESC_RST_COUNT) begin
			sum = sum - cesc_pkg::CESC_STEP_ONE;
		end
		// Saturate so a burst of errors cannot wrap back to error-active
		if (sum > cesc_pkg::CESC_CNT_MAX) begin
			sum = cesc_pkg::CESC_CNT_MAX;
		end
		count_d = load_in ? load_val_in : sum[7:0];
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			count_q <= cesc_pkg::CESC_RST_COUNT;
		end else begin
			count_q <= count_d;
		end
	end

	assign count_out = count_q;
endmodule
`default_nettype wire

// *** cesc_sticky.sv ***
// Sticky flag vector with deferred setting while held
`timescale 1ns/1ps
`default_nettype none
module cesc_sticky #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         core_clk_in,
	input  wire logic         rst_in,
	// Control
	input  wire logic [W-1:0] set_in,
	input  wire logic [W-1:0] clr_in,
	input  wire logic         hold_in,
	// Flags
	output logic [W-1:0]      flag_out
);
	logic [W-1:0] flag_q;
	logic [W-1:0] pend_q;

	// Events seen while held are kept and shown only on release
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			pend_q <= '0;
		end else if (hold_in) begin
			pend_q <= pend_q | set_in;
		end else begin
			pend_q <= '0;
		end
	end

	// Set wins over clear in the same cycle
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			flag_q <= '0;
		end else if (hold_in) begin
			flag_q <= flag_q & ~clr_in;
		end else begin
			flag_q <= (flag_q & ~clr_in) | set_in | pend_q;
		end
	end

	assign flag_out = flag_q;
endmodule
`default_nettype wire

// *** cesc_top.sv ***
// CAN error counters and error flags with AXI4-Lite register access
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Fast-phase receive error counter sits in bits 31:24 of error_counters.
// - Fast-phase transmit error counter sits in bits 23:16 of error_counters.
// - Fast-phase counters take writes of zero only, and only in Inactive mode.
// - Standard receive counter in bits 15:8, standard transmit counter in 7:0.
// - error_counters is read-only outside Inactive mode; only full word writes.
// - Fast bit-recessive error flag, bit 31, set on dominant readback.
// - Fast bit-dominant error flag, bit 30, set on recessive readback.
// - Fast CRC, form and stuff error flags at bits 28, 27, 26.
// - Overrun flag, bit 21, set by a new error while any fast or standard error cause flag is set.
// - Bit 20 is the OR of the five fast-phase error flags.
// - Bit 19 set when bus-off recovery sequence is detected.
// - Bit 18 shows bus synchronization, read-only.
// - Bit 17 set on rising Tx warning, never while bus-off.
// - Bit 16 set on rising Rx warning.
// - Bits 15 and 14 flag bit-recessive and bit-dominant errors, any format.
// - Bits 13 to 10 flag acknowledge, CRC, form and stuffing errors.
// - Standard flags and Rx warning irq flag refresh on leaving Pretended Networking.
// - Bit 9 high while standard transmit counter is 96 or more.
// - Bit 8 high while standard receive counter is 96 or more.
// - Bit 1 is the OR of flag bits 15 to 10.
module cesc_top (
	// Clock and reset
	input  wire logic                    core_clk_in,
	input  wire logic                    rst_in,
	// AXI4-Lite write address and data
	input  wire logic                    s_axi_awvalid_in,
	output logic                         s_axi_awready_out,
	input  wire logic [7:0]              s_axi_awaddr_in,
	input  wire logic                    s_axi_wvalid_in,
	output logic                         s_axi_wready_out,
	input  wire logic [31:0]             s_axi_wdata_in,
	input  wire logic [3:0]              s_axi_wstrb_in,
	// AXI4-Lite write response
	output logic                         s_axi_bvalid_out,
	input  wire logic                    s_axi_bready_in,
	output logic [1:0]                   s_axi_bresp_out,
	// AXI4-Lite read
	input  wire logic                    s_axi_arvalid_in,
	output logic                         s_axi_arready_out,
	input  wire logic [7:0]              s_axi_araddr_in,
	output logic                         s_axi_rvalid_out,
	input  wire logic                    s_axi_rready_in,
	output logic [31:0]                  s_axi_rdata_out,
	output logic [1:0]                   s_axi_rresp_out,
	// Protocol engine events and modes
	input  wire cesc_pkg::cesc_evt_t     evt_in,
	input  wire cesc_pkg::cesc_cnt_cmd_t tx_cmd_in,
	input  wire cesc_pkg::cesc_cnt_cmd_t rx_cmd_in,
	input  wire cesc_pkg::cesc_cnt_cmd_t fast_tx_cmd_in,
	input  wire cesc_pkg::cesc_cnt_cmd_t fast_rx_cmd_in,
	input  wire cesc_pkg::cesc_mode_t    mode_in,
	// Status toward the protocol engine
	output cesc_pkg::cesc_counts_t       counts_out,
	output logic                         tx_warning_flag_out,
	output logic                         rx_warning_flag_out
);
	typedef enum {CESC_SEL_NONE, CESC_SEL_COUNTERS, CESC_SEL_FLAGS} cesc_sel_t;

	function automatic cesc_sel_t cesc_decode(input logic [7:0] addr);
		if (addr == cesc_pkg::CESC_OFF_ERR_COUNTERS) begin
			return CESC_SEL_COUNTERS;
		end else if (addr == cesc_pkg::CESC_OFF_ERR_FLAGS) begin
			return CESC_SEL_FLAGS;
		end
		return CESC_SEL_NONE;
	endfunction

	// Shared warning limit
	function automatic logic cesc_warn_level(input logic [7:0] count);
		return count >= cesc_pkg::CESC_WARN_LIMIT;
	endfunction

	// High now, low a cycle before
	function automatic logic cesc_rise(input logic level, input logic prev);
		return level && !prev;
	endfunction

	// Bus handshake
	logic        wr_take;
	logic        rd_take;
	logic        wr_full;
	cesc_sel_t   wr_sel;
	cesc_sel_t   rd_sel;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;

	// Register actions
	logic        cnt_wr;
	logic        fast_zero_wr;
	logic        flags_wr;
	logic        flags_rd;
	logic [31:0] w1c;

	// Counters and flags
	cesc_pkg::cesc_counts_t cnt;
	cesc_pkg::cesc_std_err_t  std_q;
	cesc_pkg::cesc_fast_err_t fast_q;
	logic        overrun_q;
	logic        recovery_q;
	logic        tx_wirq_q;
	logic        rx_wirq;
	logic        tx_warn;
	logic        rx_warn;
	logic        tx_warn_prev_q;
	logic        rx_warn_prev_q;
	logic        tx_warn_rise;
	logic        rx_warn_rise;
	logic        new_err;
	logic        any_flag;
	logic [31:0] flags_word;
	logic [31:0] counters_word;

	// Both channels must be present; the slave then takes them together
	assign wr_take  = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_q;
	assign rd_take  = s_axi_arvalid_in && !rvalid_q;
	assign wr_full  = s_axi_wstrb_in == cesc_pkg::CESC_STRB_FULL;
	assign wr_sel   = cesc_decode(s_axi_awaddr_in);
	assign rd_sel   = cesc_decode(s_axi_araddr_in);

	assign s_axi_awready_out = wr_take;
	assign s_axi_wready_out  = wr_take;
	assign s_axi_arready_out = rd_take;

	assign cnt_wr       = wr_take && wr_full && wr_sel == CESC_SEL_COUNTERS
		&& mode_in.inactive;
	assign fast_zero_wr = cnt_wr;
	assign flags_wr     = wr_take && wr_full && wr_sel == CESC_SEL_FLAGS;
	assign flags_rd     = rd_take && rd_sel == CESC_SEL_FLAGS;

	// Write-one-to-clear strobes
	assign w1c          = flags_wr ? s_axi_wdata_in : 32'h0000_0000;

	// Write response
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			bvalid_q <= 1'b0;
			bresp_q  <= cesc_pkg::CESC_RESP_OKAY;
		end else if (wr_take) begin
			bvalid_q <= 1'b1;
			if (wr_sel == CESC_SEL_NONE) begin
				bresp_q <= cesc_pkg::CESC_RESP_DECERR;
			end else if (!wr_full) begin
				bresp_q <= cesc_pkg::CESC_RESP_SLVERR;
			end else begin
				bresp_q <= cesc_pkg::CESC_RESP_OKAY;
			end
		end else if (s_axi_bready_in) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read data captured at the address handshake, before read-clear acts
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= cesc_pkg::CESC_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			unique case (rd_sel)
				CESC_SEL_COUNTERS: begin
					rdata_q <= counters_word;
					rresp_q <= cesc_pkg::CESC_RESP_OKAY;
				end
				CESC_SEL_FLAGS: begin
					rdata_q <= flags_word;
					rresp_q <= cesc_pkg::CESC_RESP_OKAY;
				end
				CESC_SEL_NONE: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= cesc_pkg::CESC_RESP_DECERR;
				end
			endcase
		end else if (s_axi_rready_in) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_bvalid_out = bvalid_q;
	assign s_axi_bresp_out  = bresp_q;
	assign s_axi_rvalid_out = rvalid_q;
	assign s_axi_rdata_out  = rdata_q;
	assign s_axi_rresp_out  = rresp_q;

	// Counters
	cesc_err_cnt u_tx_cnt (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.cmd_in      (tx_cmd_in),
		.load_in     (cnt_wr),
		.load_val_in (s_axi_wdata_in[cesc_pkg::CESC_POS_TX_CNT +: 8]),
		.count_out   (cnt.tx_error_count)
	);

	cesc_err_cnt u_rx_cnt (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.cmd_in      (rx_cmd_in),
		.load_in     (cnt_wr),
		.load_val_in (s_axi_wdata_in[cesc_pkg::CESC_POS_RX_CNT +: 8]),
		.count_out   (cnt.rx_error_count)
	);

	// Only a zero byte loads the fast counters; other values are dropped
	cesc_err_cnt u_ftx_cnt (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.cmd_in      (fast_tx_cmd_in),
		.load_in     (fast_zero_wr
			&& s_axi_wdata_in[cesc_pkg::CESC_POS_FTX_CNT +: 8] == cesc_pkg::CESC_RST_COUNT),
		.load_val_in (cesc_pkg::CESC_RST_COUNT),
		.count_out   (cnt.fast_phase_tx_error_count)
	);

	cesc_err_cnt u_frx_cnt (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.cmd_in      (fast_rx_cmd_in),
		.load_in     (fast_zero_wr
			&& s_axi_wdata_in[cesc_pkg::CESC_POS_FRX_CNT +: 8] == cesc_pkg::CESC_RST_COUNT),
		.load_val_in (cesc_pkg::CESC_RST_COUNT),
		.count_out   (cnt.fast_phase_rx_error_count)
	);

	assign counters_word = cnt;
	assign counts_out    = cnt;

	// Warning levels
	assign tx_warn = cesc_warn_level(cnt.tx_error_count);
	assign rx_warn = cesc_warn_level(cnt.rx_error_count);
	assign tx_warning_flag_out = tx_warn;
	assign rx_warning_flag_out = rx_warn;

	// Levels start low, so reset gives no edge
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			tx_warn_prev_q <= 1'b0;
			rx_warn_prev_q <= 1'b0;
		end else begin
			tx_warn_prev_q <= tx_warn;
			rx_warn_prev_q <= rx_warn;
		end
	end

	assign tx_warn_rise = cesc_rise(tx_warn, tx_warn_prev_q);
	assign rx_warn_rise = cesc_rise(rx_warn, rx_warn_prev_q);

	// Standard-phase cause flags and Rx warning irq wait out Pretended Networking
	cesc_sticky #(.W(6)) u_std_flags (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.set_in      (evt_in.std_err),
		.clr_in      ({6{flags_rd}}),
		.hold_in     (mode_in.pretended_net),
		.flag_out    (std_q)
	);

	cesc_sticky #(.W(1)) u_rx_wirq (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.set_in      (rx_warn_rise),
		.clr_in      (w1c[cesc_pkg::CESC_POS_RX_WIRQ]),
		.hold_in     (mode_in.pretended_net),
		.flag_out    (rx_wirq)
	);

	// Fast-phase causes are never deferred
	cesc_sticky #(.W(5)) u_fast_flags (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.set_in      (evt_in.fast_err),
		.clr_in      ({5{flags_rd}}),
		.hold_in     (1'b0),
		.flag_out    (fast_q)
	);

	// Overrun looks at flags as currently visible
	assign new_err  = |evt_in.std_err || |evt_in.fast_err;
	assign any_flag = |std_q || |fast_q;

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			overrun_q <= 1'b0;
		end else if (new_err && any_flag) begin
			overrun_q <= 1'b1;
		end else if (w1c[cesc_pkg::CESC_POS_OVERRUN]) begin
			overrun_q <= 1'b0;
		end
	end

	// Set wins over a write-one clear
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			recovery_q <= 1'b0;
		end else if (evt_in.busoff_recovery) begin
			recovery_q <= 1'b1;
		end else if (w1c[cesc_pkg::CESC_POS_RECOVERY]) begin
			recovery_q <= 1'b0;
		end
	end

	// The Tx warning irq is meaningless while the node is off the bus
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			tx_wirq_q <= 1'b0;
		end else if (tx_warn_rise && !mode_in.bus_off) begin
			tx_wirq_q <= 1'b1;
		end else if (w1c[cesc_pkg::CESC_POS_TX_WIRQ]) begin
			tx_wirq_q <= 1'b0;
		end
	end

	// Read view of error_flags; unlisted bits read as zero
	always_comb begin
		flags_word = 32'h0000_0000;
		flags_word[cesc_pkg::CESC_POS_FAST_REC]  = fast_q.fast_bit_recessive_error;
		flags_word[cesc_pkg::CESC_POS_FAST_DOM]  = fast_q.fast_bit_dominant_error;
		flags_word[cesc_pkg::CESC_POS_FAST_CRC]  = fast_q.fast_checksum_error;
		flags_word[cesc_pkg::CESC_POS_FAST_FORM] = fast_q.fast_form_error;
		flags_word[cesc_pkg::CESC_POS_FAST_STUF] = fast_q.fast_stuffing_error;
		flags_word[cesc_pkg::CESC_POS_OVERRUN]   = overrun_q;
		flags_word[cesc_pkg::CESC_POS_FAST_SUM]  = |fast_q;
		flags_word[cesc_pkg::CESC_POS_RECOVERY]  = recovery_q;
		flags_word[cesc_pkg::CESC_POS_SYNC]      = mode_in.bus_synchronized;
		flags_word[cesc_pkg::CESC_POS_TX_WIRQ]   = tx_wirq_q;
		flags_word[cesc_pkg::CESC_POS_RX_WIRQ]   = rx_wirq;
		flags_word[cesc_pkg::CESC_POS_STD_LSB +: 6] = std_q;
		flags_word[cesc_pkg::CESC_POS_TX_WARN]   = tx_warn;
		flags_word[cesc_pkg::CESC_POS_RX_WARN]   = rx_warn;
		flags_word[cesc_pkg::CESC_POS_STD_SUM]   = |std_q;
	end
endmodule
`default_nettype wire

// *** cesc_engine_model.sv ***
// Behavioural protocol engine that feeds error events, counter steps and modes
`timescale 1ns/1ps
`default_nettype none
module cesc_engine_model (
	// Clock
	input  wire logic                   core_clk_in,
	// Toward the block
	output var cesc_pkg::cesc_evt_t     evt_out,
	output var cesc_pkg::cesc_cnt_cmd_t tx_cmd_out,
	output var cesc_pkg::cesc_cnt_cmd_t rx_cmd_out,
	output var cesc_pkg::cesc_cnt_cmd_t fast_tx_cmd_out,
	output var cesc_pkg::cesc_cnt_cmd_t fast_rx_cmd_out,
	output var cesc_pkg::cesc_mode_t    mode_out
);
	initial begin
		evt_out = '0;
		{tx_cmd_out, rx_cmd_out, fast_tx_cmd_out, fast_rx_cmd_out} = 12'h000;
		mode_out = 4'h1;
	end
	// Events are single-cycle pulses; the gap lets the engine answer slowly
	task automatic pulse(input cesc_pkg::cesc_evt_t e, input int gap);
		evt_out <= e;
		@(posedge core_clk_in);
		evt_out <= '0;
		repeat (gap) @(posedge core_clk_in);
	endtask
	task automatic step(input logic [11:0] c);
		{tx_cmd_out, rx_cmd_out, fast_tx_cmd_out, fast_rx_cmd_out} <= c;
		@(posedge core_clk_in);
	endtask
	task automatic set_mode(input cesc_pkg::cesc_mode_t m);
		mode_out <= m;
		@(posedge core_clk_in);
	endtask
endmodule
`default_nettype wire

// *** cesc_top_monitor.sv ***
// Assertion checker for the error counter and status block
`timescale 1ns/1ps
`default_nettype none
module cesc_top_monitor (
	// Clock and reset
	input wire logic                    core_clk_in,
	input wire logic                    rst_in,
	// Register bus
	input wire logic                    s_axi_awvalid_in,
	input wire logic                    s_axi_awready_out,
	input wire logic [7:0]              s_axi_awaddr_in,
	input wire logic [31:0]             s_axi_wdata_in,
	input wire logic [3:0]              s_axi_wstrb_in,
	input wire logic                    s_axi_arvalid_in,
	input wire logic                    s_axi_arready_out,
	input wire logic [7:0]              s_axi_araddr_in,
	input wire logic                    s_axi_rvalid_out,
	input wire logic [31:0]             s_axi_rdata_out,
	// Engine side
	input wire cesc_pkg::cesc_cnt_cmd_t tx_cmd_in,
	input wire cesc_pkg::cesc_cnt_cmd_t rx_cmd_in,
	input wire cesc_pkg::cesc_cnt_cmd_t fast_tx_cmd_in,
	input wire cesc_pkg::cesc_cnt_cmd_t fast_rx_cmd_in,
	input wire cesc_pkg::cesc_mode_t    mode_in,
	input wire cesc_pkg::cesc_counts_t  counts_out,
	input wire logic                    tx_warning_flag_out,
	input wire logic                    rx_warning_flag_out
);
	logic [7:0]  rd_addr_q;
	logic        cnt_wr;
	logic        full_ld;
	logic        no_step;
	logic [15:0] std_wr;
	logic [31:0] rd;
	assign cnt_wr = s_axi_awvalid_in && s_axi_awready_out
		&& s_axi_awaddr_in == cesc_pkg::CESC_OFF_ERR_COUNTERS;
	assign full_ld = cnt_wr && mode_in.inactive && s_axi_wstrb_in == 4'hf;
	assign no_step = {tx_cmd_in, rx_cmd_in, fast_tx_cmd_in, fast_rx_cmd_in} == 12'h000;
	assign std_wr = s_axi_wdata_in[15:0];
	assign rd = s_axi_rdata_out;
	// Address of the read whose answer is pending
	always_ff @(posedge core_clk_in) begin
		if (rst_in) rd_addr_q <= 8'h00;
		else if (s_axi_arvalid_in && s_axi_arready_out) rd_addr_q <= s_axi_araddr_in;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	AST_FAST_SUM: assert property ($rose(s_axi_rvalid_out) && rd_addr_q == 8'h20
		|-> rd[20] == |{rd[31:30], rd[28:26]}) else $error("fast summary wrong");
	AST_STD_SUM: assert property ($rose(s_axi_rvalid_out) && rd_addr_q == 8'h20
		|-> rd[1] == |rd[15:10]) else $error("standard summary wrong");
	AST_CNT_READ: assert property ($rose(s_axi_rvalid_out) && rd_addr_q == 8'h1c
		|-> rd == $past(counts_out)) else $error("counter readback wrong");
	AST_RO_OUTSIDE: assert property (cnt_wr && !mode_in.inactive && no_step
		|=> $stable(counts_out)) else $error("counters written outside inactive");
	AST_FAST_ZERO: assert property (full_ld && s_axi_wdata_in[31:24] != 8'h00
		&& fast_rx_cmd_in == 3'h0 |=> $stable(counts_out.fast_phase_rx_error_count))
		else $error("fast counter took nonzero write");
	AST_FAST_CLEAR: assert property (full_ld && s_axi_wdata_in[23:16] == 8'h00
		|=> counts_out.fast_phase_tx_error_count == 8'h00) else $error("fast clear lost");
	AST_STD_LOAD: assert property (full_ld |=> counts_out[15:0] == $past(std_wr))
		else $error("standard counters not loaded");
	AST_TX_WARN: assert property (tx_warning_flag_out
		== (counts_out.tx_error_count >= 8'h60)) else $error("tx warning wrong");
	AST_RX_WARN: assert property (rx_warning_flag_out
		== (counts_out.rx_error_count >= 8'h60)) else $error("rx warning wrong");
endmodule
bind cesc_top cesc_top_monitor i_cesc_top_monitor (
	.core_clk_in(core_clk_in), .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_awaddr_in(s_axi_awaddr_in),
	.s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_araddr_in(s_axi_araddr_in), .s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rdata_out(s_axi_rdata_out), .tx_cmd_in(tx_cmd_in), .rx_cmd_in(rx_cmd_in),
	.fast_tx_cmd_in(fast_tx_cmd_in), .fast_rx_cmd_in(fast_rx_cmd_in), .mode_in(mode_in),
	.counts_out(counts_out), .tx_warning_flag_out(tx_warning_flag_out),
	.rx_warning_flag_out(rx_warning_flag_out)
);
`default_nettype wire

// *** tb.sv ***
// Self-checking testbench for the error counter and status block
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [7:0] CNT = cesc_pkg::CESC_OFF_ERR_COUNTERS;
	localparam logic [7:0] FLG = cesc_pkg::CESC_OFF_ERR_FLAGS;
	logic core_clk_in, rst_in, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, txw, rxw;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, fl, pend, seed;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	cesc_pkg::cesc_evt_t evt;
	cesc_pkg::cesc_cnt_cmd_t txc, rxc, ftxc, frxc;
	cesc_pkg::cesc_mode_t mode;
	cesc_pkg::cesc_counts_t counts;
	int mismatches, checks;
	int cnt[4];
	cesc_top i_cesc_top (.core_clk_in(core_clk_in), .rst_in(rst_in),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .evt_in(evt), .tx_cmd_in(txc),
		.rx_cmd_in(rxc), .fast_tx_cmd_in(ftxc), .fast_rx_cmd_in(frxc), .mode_in(mode),
		.counts_out(counts), .tx_warning_flag_out(txw), .rx_warning_flag_out(rxw));
	cesc_engine_model i_cesc_engine_model (.core_clk_in(core_clk_in), .evt_out(evt),
		.tx_cmd_out(txc), .rx_cmd_out(rxc), .fast_tx_cmd_out(ftxc), .fast_rx_cmd_out(frxc),
		.mode_out(mode));
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic final_report();
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	function automatic int nxt(input int v, input logic [2:0] k);
		if (k[1]) return (v > 247) ? 255 : v + 8;
		if (k[2]) return (v == 255) ? 255 : v + 1;
		if (k[0]) return (v == 0) ? 0 : v - 1;
		return v;
	endfunction
	function automatic logic [31:0] expf();
		logic [31:0] f;
		f = fl;
		f[20] = |(fl & 32'hdc00_0000);
		f[1] = |fl[15:10];
		f[18] = mode.bus_synchronized;
		f[9] = cnt[0] >= 'h60;
		f[8] = cnt[1] >= 'h60;
		return f;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] er;
		er = (a != CNT && a != FLG) ? 2'h3 : (s == 4'hf) ? 2'h0 : 2'h2;
		awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= d; wstrb <= s; bready <= 1'b1;
		@(posedge core_clk_in);
		while (!(awready && wready)) @(posedge core_clk_in);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge core_clk_in);
		while (!bvalid) @(posedge core_clk_in);
		check("bresp", {30'h0, bresp}, {30'h0, er});
		bready <= 1'b0;
		@(posedge core_clk_in);
		if (er == 2'h0 && a == CNT && mode.inactive) begin
			cnt[0] = d[7:0];
			cnt[1] = d[15:8];
			if (d[23:16] == 8'h00) cnt[2] = 0;
			if (d[31:24] == 8'h00) cnt[3] = 0;
		end
		if (er == 2'h0 && a == FLG) fl &= ~(d & 32'h002b_0000);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m);
		logic [31:0] e;
		logic [31:0] c;
		logic [31:0] f;
		c = {8'(cnt[3]), 8'(cnt[2]), 8'(cnt[1]), 8'(cnt[0])};
		f = expf();
		e = (a == CNT) ? c : (a == FLG) ? f : 32'h0;
		arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
		@(posedge core_clk_in);
		while (!arready) @(posedge core_clk_in);
		arvalid <= 1'b0;
		@(posedge core_clk_in);
		while (!rvalid) @(posedge core_clk_in);
		check("rdata", rdata & m, e & m);
		check("rresp", {30'h0, rresp}, (a == CNT || a == FLG) ? 32'h0 : 32'h3);
		check("counts", counts, c);
		check("warnings", {30'h0, txw, rxw}, {30'h0, f[9:8]});
		rready <= 1'b0;
		@(posedge core_clk_in);
		if (a == FLG) fl &= ~32'hdc00_fc00;
	endtask
	task automatic ev(input logic [11:0] e);
		logic [31:0] s;
		s = {e[5], e[4], 1'b0, e[3:1], 6'h0, e[0], 3'h0, e[11:6], 10'h0};
		if ((s & 32'hdc00_fc00) != 0 && (fl & 32'hdc00_fc00) != 0) fl[21] = 1'b1;
		if (mode.pretended_net) begin
			pend |= s & 32'h0000_fc00;
			s &= ~32'h0000_fc00;
		end
		fl |= s;
		seed = lfsr(seed);
		i_cesc_engine_model.pulse(e, 1 + int'(seed[1:0]));
	endtask
	task automatic st(input logic [11:0] c);
		logic tw, rw;
		tw = cnt[0] >= 'h60;
		rw = cnt[1] >= 'h60;
		for (int i = 0; i < 4; i++) cnt[i] = nxt(cnt[i], c[11 - 3 * i -: 3]);
		if (!tw && cnt[0] >= 'h60 && !mode.bus_off) fl[17] = 1'b1;
		if (!rw && cnt[1] >= 'h60) fl[16] = 1'b1;
		i_cesc_engine_model.step(c);
	endtask
	initial begin
		repeat (20000) @(posedge core_clk_in);
		mismatches++;
		final_report();
	end
	initial begin
		rst_in = 1'b1; {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 8'h0; araddr = 8'h0; wdata = 32'h0; wstrb = 4'h0;
		fl = 32'h0; pend = 32'h0; seed = 32'h0001_810f; cnt = '{0, 0, 0, 0};
		repeat (4) @(posedge core_clk_in);
		rst_in <= 1'b0;
		@(posedge core_clk_in);
		rd(CNT, '1);
		rd(FLG, '1);
		for (int i = 1; i < 12; i++) begin
			ev(12'h001 << i);
			rd(FLG, '1);
		end
		ev(12'h100);
		ev(12'h002);
		rd(FLG, '1);
		wr(FLG, 32'h0, 4'hf);
		rd(FLG, '1);
		wr(FLG, 32'h0020_0000, 4'hf);
		rd(FLG, '1);
		ev(12'h001);
		rd(FLG, '1);
		wr(FLG, 32'hffff_ffff, 4'hf);
		rd(FLG, '1);
		i_cesc_engine_model.set_mode(4'h5);
		ev(12'h100);
		rd(FLG, '1);
		i_cesc_engine_model.set_mode(4'h1);
		fl |= pend;
		repeat (2) @(posedge core_clk_in);
		rd(FLG, '1);
		repeat (300) begin
			seed = lfsr(seed);
			st(seed[11:0]);
		end
		st(12'h000);
		rd(CNT, '1);
		rd(FLG, ~32'h0020_0000);
		wr(FLG, 32'h002b_0000, 4'hf);
		fl[21] = 1'b0;
		i_cesc_engine_model.set_mode(4'h9);
		wr(CNT, 32'h0500_5f5f, 4'hf);
		rd(CNT, '1);
		wr(CNT, 32'h0, 4'h3);
		wr(8'h24, 32'h0, 4'hf);
		rd(8'h24, '1);
		wr(CNT, 32'h0000_5f5f, 4'hf);
		rd(CNT, '1);
		i_cesc_engine_model.set_mode(4'h3);
		wr(CNT, 32'h0, 4'hf);
		st(12'h900);
		st(12'h000);
		rd(CNT, '1);
		rd(FLG, '1);
		final_report();
	end
endmodule
`default_nettype wire
